// file: rtl/adcat_phase_counter.sv
// phase counter: precharge, then acquisition, then conversion start pulse
`timescale 1ns/1ps
`default_nettype none
module adcat_phase_counter (
    input  wire logic  clock,
    input  wire logic  reset,
    input  wire logic  clock_enable,
    adcat_timer_if.timer tif
);
    adcat_pkg::adcat_phase_t phase;
    logic [13:0]             count;
    logic [13:0]             acq_cycles;

    // zero count with precharge means one beyond the largest count
    always_comb begin
        if (tif.acquisition_count != 13'h0000) begin
            acq_cycles = {1'b0, tif.acquisition_count};
        end else if (tif.precharge_time_setting != 8'h00) begin
            acq_cycles = adcat_pkg::ZERO_CASE_CYCLES;
        end else begin
            acq_cycles = 14'h0000;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            phase             <= adcat_pkg::ADCAT_IDLE;
            count             <= 14'h0000;
            tif.convert_start <= 1'b0;
        end else if (clock_enable) begin
            tif.convert_start <= 1'b0;
            unique case (phase)
                adcat_pkg::ADCAT_IDLE: begin
                    if (tif.start) begin
                        if (tif.precharge_time_setting != 8'h00) begin
                            phase <= adcat_pkg::ADCAT_PRECHARGE;
                            count <= {6'h00, tif.precharge_time_setting};
                        end else if (acq_cycles != 14'h0000) begin
                            phase <= adcat_pkg::ADCAT_ACQUIRE;
                            count <= acq_cycles;
                        end else begin
                            phase             <= adcat_pkg::ADCAT_CONVERT;
                            tif.convert_start <= 1'b1;
                        end
                    end
                end
                adcat_pkg::ADCAT_PRECHARGE: begin
                    if (count == 14'h0001) begin
                        phase <= adcat_pkg::ADCAT_ACQUIRE;
                        count <= acq_cycles;
                    end else begin
                        count <= count - 14'h0001;
                    end
                end
                adcat_pkg::ADCAT_ACQUIRE: begin
                    if (count == 14'h0001) begin
                        // pulse as the count ends, so it meets the falling acquisition flag
                        phase             <= adcat_pkg::ADCAT_CONVERT;
                        tif.convert_start <= 1'b1;
                    end else begin
                        count <= count - 14'h0001;
                    end
                end
                adcat_pkg::ADCAT_CONVERT: begin
                    phase <= adcat_pkg::ADCAT_IDLE;
                end
            endcase
        end
    end

    assign tif.phase = phase;
    assign tif.busy  = (phase != adcat_pkg::ADCAT_IDLE);
endmodule
`default_nettype wire

// file: rtl/adcat_pkg.sv
// package: register map, field layout and reset values of the acquisition timer
package adcat_pkg;
    localparam int          ACQ_WIDTH          = 13;
    localparam logic [11:0] OFFSET_ACQ_LOW     = 12'h000;
    localparam logic [11:0] OFFSET_ACQ_HIGH    = 12'h004;
    localparam logic [11:0] OFFSET_CONTROL     = 12'h008;
    localparam logic [11:0] OFFSET_STATUS      = 12'h00c;
    localparam int          LOW_MSB            = 7;
    localparam int          HIGH_MSB           = 4;
    localparam logic [7:0]  RESET_ACQ_LOW      = 8'h00;
    localparam logic [7:0]  RESET_ACQ_HIGH     = 8'h00;
    localparam logic [7:0]  RESET_PRECHARGE    = 8'h00;
    localparam int          CONTROL_START_BIT  = 0;
    localparam int          PRECHARGE_LSB      = 8;
    localparam int          STATUS_BUSY_BIT    = 0;
    localparam int          STATUS_PHASE_LSB   = 1;
    localparam logic [13:0] ZERO_CASE_CYCLES   = 14'h2000;
    typedef enum logic [1:0] {
        ADCAT_IDLE      = 2'b00,
        ADCAT_PRECHARGE = 2'b01,
        ADCAT_ACQUIRE   = 2'b10,
        ADCAT_CONVERT   = 2'b11
    } adcat_phase_t;
endpackage

// file: rtl/adcat_timer_if.sv
// interface: sequencing signals between register front end and phase counter
`timescale 1ns/1ps
`default_nettype none
interface adcat_timer_if;
    logic                             start;
    logic [12:0]                      acquisition_count;
    logic [7:0]                       precharge_time_setting;
    logic                             busy;
    logic                             convert_start;
    adcat_pkg::adcat_phase_t          phase;
    modport ctrl  (output start, output acquisition_count, output precharge_time_setting,
                   input busy, input convert_start, input phase);
    modport timer (input start, input acquisition_count, input precharge_time_setting,
                   output busy, output convert_start, output phase);
endinterface
`default_nettype wire

// file: rtl/adcat_top.sv
// top: apb register file and acquisition sequencing of the converter
//
// How it works
// - low register holds count bits seven..zero
// - high register holds count bits twelve..eight
// - high bits seven..five read zero, ignored
// - nonzero count gives exactly that many cycles
// - zero count, zero precharge skips acquisition
// - zero count with precharge gives 8192 cycles
`timescale 1ns/1ps
`default_nettype none
module adcat_top (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        clock_enable,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             acquiring,
    output logic             precharging,
    output logic             convert_start
);
    adcat_timer_if tif ();

    logic [7:0]  acquisition_time_low;
    logic [4:0]  acquisition_time_high;
    logic [7:0]  precharge_time_setting;
    logic        start_pulse;
    logic        access;
    logic        commit;
    logic        write_low;
    logic        write_high;
    logic        write_start;
    logic        write_precharge;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    adcat_phase_counter u_counter (
        .clock        (clock),
        .reset        (reset),
        .clock_enable (clock_enable),
        .tif          (tif)
    );

    assign tif.start                  = start_pulse;
    assign tif.acquisition_count      = {acquisition_time_high, acquisition_time_low};
    assign tif.precharge_time_setting = precharge_time_setting;

    // shared decode for every write strobe: answering edge, address and lane
    function automatic logic lane_write(input logic        answered,
                                        input logic [11:0] addr,
                                        input logic [11:0] offset,
                                        input logic        lane);
        return answered && (addr == offset) && lane;
    endfunction

    // one-wait answer: ready rises in the second access cycle
    assign access = psel && penable && !pready;

    // writes land only at the edge that samples ready high, never earlier
    assign commit          = psel && penable && pready && pwrite;
    assign write_low       = lane_write(commit, paddr, adcat_pkg::OFFSET_ACQ_LOW, pstrb[0]);
    assign write_high      = lane_write(commit, paddr, adcat_pkg::OFFSET_ACQ_HIGH, pstrb[0]);
    assign write_start     = lane_write(commit, paddr, adcat_pkg::OFFSET_CONTROL, pstrb[0]);
    assign write_precharge = lane_write(commit, paddr, adcat_pkg::OFFSET_CONTROL, pstrb[1]);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
        end else if (clock_enable) begin
            pready <= psel && penable && !pready;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            acquisition_time_low <= adcat_pkg::RESET_ACQ_LOW;
        end else if (clock_enable && write_low) begin
            acquisition_time_low <= pwdata[adcat_pkg::LOW_MSB:0];
        end
    end

    // only five bits are stored, so the upper three cannot read back
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            acquisition_time_high <= adcat_pkg::RESET_ACQ_HIGH[adcat_pkg::HIGH_MSB:0];
        end else if (clock_enable && write_high) begin
            acquisition_time_high <= pwdata[adcat_pkg::HIGH_MSB:0];
        end
    end

    // precharge setting sits in byte lane one of the control word
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            precharge_time_setting <= adcat_pkg::RESET_PRECHARGE;
        end else if (clock_enable && write_precharge) begin
            precharge_time_setting <= pwdata[adcat_pkg::PRECHARGE_LSB +: 8];
        end
    end

    // a start while busy is dropped rather than queued
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            start_pulse <= 1'b0;
        end else if (clock_enable) begin
            start_pulse <= write_start && pwdata[adcat_pkg::CONTROL_START_BIT] && !tif.busy;
        end
    end

    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        unique case (paddr)
            adcat_pkg::OFFSET_ACQ_LOW:  next_prdata[7:0] = acquisition_time_low;
            adcat_pkg::OFFSET_ACQ_HIGH: next_prdata[4:0] = acquisition_time_high;
            adcat_pkg::OFFSET_CONTROL:
                next_prdata[adcat_pkg::PRECHARGE_LSB +: 8] = precharge_time_setting;
            adcat_pkg::OFFSET_STATUS: begin
                next_prdata[adcat_pkg::STATUS_BUSY_BIT]       = tif.busy;
                next_prdata[adcat_pkg::STATUS_PHASE_LSB +: 2] = tif.phase;
            end
            default: next_pslverr = 1'b1;
        endcase
    end

    // read data stands until the next access replaces it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (clock_enable && access) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        end
    end

    // error flag pulses together with ready
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pslverr <= 1'b0;
        end else if (clock_enable) begin
            pslverr <= access && next_pslverr;
        end
    end

    // outputs registered; they trail the internal phase by one cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            acquiring <= 1'b0;
        end else if (clock_enable) begin
            acquiring <= (tif.phase == adcat_pkg::ADCAT_ACQUIRE);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            precharging <= 1'b0;
        end else if (clock_enable) begin
            precharging <= (tif.phase == adcat_pkg::ADCAT_PRECHARGE);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            convert_start <= 1'b0;
        end else if (clock_enable) begin
            convert_start <= tif.convert_start;
        end
    end
endmodule
`default_nettype wire

// file: tb/adcat_top_bench.sv
// bench: apb register and acquisition timing tests of the timer
`timescale 1ns/1ps
`default_nettype none
module adcat_top_bench;
    logic        clock, reset, clock_enable, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        pready, pslverr, acquiring, precharging, convert_start;
    int          n_fail, n_tests, len;
    logic [31:0] rq[$], dq[$];
    adcat_top u_dut (.clock(clock), .reset(reset), .clock_enable(clock_enable),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .acquiring(acquiring), .precharging(precharging), .convert_start(convert_start));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        rq.push_back(e);
        apb(1'b0, a, 32'h0, r);
    endtask
    // reads and acquisition lengths are judged here, against the oldest note
    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0)
            check(prdata, rq.pop_front());
        if (acquiring === 1'b1) len++;
        else if (len > 0) begin
            check(32'(len), dq.size() > 0 ? dq.pop_front() : 32'h0);
            len = 0;
        end
    end
    initial begin
        int          cnts[5] = '{1, 8191, 0, 0, 0};
        int          pres[5] = '{0, 2, 3, 0, 5};
        logic [7:0]  lo, hi;
        logic [31:0] r;
        int          k, n;
        reset = 1'b1;
        clock_enable = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        void'($urandom(40));
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        lo = 8'($urandom);
        hi = 8'($urandom);
        apb(1'b1, 12'h000, {24'h0, lo}, r);
        apb(1'b1, 12'h004, {24'hffffff, hi}, r);
        rd(12'h000, {24'h0, lo});
        rd(12'h004, {27'h0, hi[4:0]});
        rd(12'h010, 32'h0);
        cnts[4] = $urandom_range(300, 1);
        for (k = 0; k < 5; k++) begin
            // a start while busy is dropped, so wait for idle first
            do apb(1'b0, 12'h00c, 32'h0, r); while (r[0] !== 1'b0);
            apb(1'b1, 12'h000, cnts[k] & 32'hff, r);
            apb(1'b1, 12'h004, cnts[k] >> 8, r);
            if (cnts[k] != 0) dq.push_back(cnts[k]);
            else if (pres[k] != 0) dq.push_back(32'd8192);
            apb(1'b1, 12'h008, (pres[k] << 8) | 1, r);
            n = 0;
            while (convert_start !== 1'b1 && n < 9000) begin
                @(posedge clock);
                n++;
            end
            check({31'h0, convert_start}, 32'h1);
        end
        repeat (3) @(posedge clock);
        summarize();
    end
    initial begin
        #400000;
        n_fail++;
        summarize();
    end
endmodule
bind adcat_top adcat_top_monitor u_mon (.clock(clock), .reset(reset),
    .clock_enable(clock_enable), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .acquiring(acquiring), .precharging(precharging),
    .convert_start(convert_start));
`default_nettype wire

// file: tb/adcat_top_monitor.sv
// checker: port-level register and phase timing checks
`timescale 1ns/1ps
`default_nettype none
module adcat_top_monitor (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        clock_enable,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        acquiring,
    input wire logic        precharging,
    input wire logic        convert_start
);
    logic [7:0]  low;
    logic [4:0]  high;
    logic [7:0]  pre;
    logic [13:0] len;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // shadow of what software wrote, so readback can be judged
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            low <= 8'h00;
            high <= 5'h00;
            pre <= 8'h00;
        end else if (psel && penable && pready && pwrite && clock_enable) begin
            if (paddr == 12'h000 && pstrb[0]) low <= pwdata[7:0];
            if (paddr == 12'h004 && pstrb[0]) high <= pwdata[4:0];
            if (paddr == 12'h008 && pstrb[1]) pre <= pwdata[15:8];
        end
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) len <= 14'h0000;
        else if (acquiring) len <= len + 14'h0001;
        else len <= 14'h0000;
    end
    a_read_low: assert property (pready && !pwrite && paddr == 12'h000 |->
        prdata[7:0] == low) else $error("low count byte readback wrong");
    a_high_value: assert property (pready && !pwrite && paddr == 12'h004 |->
        prdata[4:0] == high) else $error("high count bits readback wrong");
    a_high_unused: assert property (pready && !pwrite && paddr == 12'h004 |->
        prdata[31:5] == 27'h0000000) else $error("unused high bits not zero");
    a_acq_length: assert property ($fell(acquiring) |-> len == (
        {high, low} == 13'h0000 ? adcat_pkg::ZERO_CASE_CYCLES : {1'b0, high, low}))
        else $error("acquisition length wrong");
    a_skip_acq: assert property ({high, low, pre} == 21'h000000 |-> !acquiring)
        else $error("acquisition not skipped");
    a_acq_after_pre: assert property ($fell(precharging) |-> acquiring)
        else $error("acquisition did not follow precharge");
    a_conv_after: assert property ($fell(acquiring) |-> convert_start)
        else $error("no conversion start after acquisition");
    a_conv_pulse: assert property (convert_start |=> !convert_start)
        else $error("conversion start longer than one cycle");
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    a_unmapped_error: assert property (pready |-> pslverr == !(paddr inside {12'h000,
        12'h004, 12'h008, 12'h00c})) else $error("error response on wrong address");
endmodule
`default_nettype wire
